/* logic/ram_decode_defines.svh */
// Offsets, field positions, reset values and window limits of the on-chip RAM decoder.
// Assumes it is included by bare name from every file that needs these constants.
`ifndef RAM_DECODE_DEFINES_SVH
`define RAM_DECODE_DEFINES_SVH

// System control register: lower 16 address bits, reset value, RAM enable bit.
`define SYSTEM_CONTROL_OFS 16'hFFF2
`define SYSTEM_CONTROL_RESET 8'h0B
`define MEM_EN_BIT 0

// RAM window limits in the lower 16 address bits, per memory size.
`define WIN_BASE_2K 16'hF710
`define WIN_BASE_1K 16'hFB10
`define WIN_BASE_512 16'hFD10
`define WIN_TOP 16'hFF0F
// Upper address nibble that mode 1 also compares.
`define WIN_UPPER 4'hF

// Operating mode pin codes.
`define MODE_ONE 2'h1
`define MODE_TWO 2'h2
`define MODE_THREE 2'h3

// Read value of a disabled window in modes 2 and 3.
`define ALL_ONES 16'hFFFF

`endif

/* logic/ram_decode_pkg.sv */
// Types shared by the on-chip RAM decoder and its memory.
// Assumes nothing of its surroundings.
package ram_decode_pkg;
  // Sizes of on-chip RAM that the decoder can be built for.
  typedef enum logic [1:0] {SIZE_2K, SIZE_1K, SIZE_512} size_t;
  // Source of the data that a CPU read returns.
  typedef enum logic [1:0] {SRC_WORD, SRC_BYTE_HI, SRC_BYTE_LO, SRC_ONES} rd_src_t;
endpackage

/* logic/pin_sync.sv */
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes a synchronous active-low reset; the reset value is a parameter constant.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // Only the second stage is visible outside, so nothing samples the metastable stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

/* logic/ram_store.sv */
// On-chip static RAM of 1024 words of 16 bits with byte-lane writes and a read register.
// Assumes the decoder gives it a word index, lane enables and the read source.
`timescale 1ns/1ps
module ram_store (
  input wire logic clk,
  input wire logic [9:0] addr,
  input wire logic [1:0] we,
  input wire logic [15:0] wdata,
  input wire logic rd_en,
  input wire ram_decode_pkg::rd_src_t rd_src,
  output logic [15:0] rdata
);
  import ram_decode_pkg::*;
  `include "ram_decode_defines.svh"

  logic [15:0] word;
  logic [15:0] rdata_r;

  // Each byte lane is its own array so a byte write leaves the other lane untouched.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : lane
      logic [7:0] mem [0:1023];
      always_ff @(posedge clk) begin
        if (we[g]) begin
          mem[addr] <= wdata[g*8 +: 8];
        end
      end
      assign word[g*8 +: 8] = mem[addr];
    end
  endgenerate

  // Read data are registered; a byte read lands in the low lane with zeros above.
  always_ff @(posedge clk) begin
    if (rd_en) begin
      case (rd_src)
        SRC_WORD: rdata_r <= word;
        SRC_BYTE_HI: rdata_r <= {8'h00, word[15:8]};
        SRC_BYTE_LO: rdata_r <= {8'h00, word[7:0]};
        SRC_ONES: rdata_r <= `ALL_ONES;
        default: rdata_r <= `ALL_ONES;
      endcase
    end
  end

  assign rdata = rdata_r;
endmodule

/* logic/onchip_ram_decode_enable.sv */
// Address decode and enable gating for the on-chip static RAM, with the system control register.
// Assumes a CPU on the same clock issuing one-cycle strobes, and mode, standby and reset pins from outside.
//
// Behaviour
// - Every byte or word access to the on-chip RAM completes in two states over a 16-bit path.
// - The 2 kbyte window is FF710 to FFF0F in mode 1, and F710 to FF0F in modes 2 and 3.
// - The 1 kbyte window starts at FFB10 in mode 1 and at FB10 in modes 2 and 3, same top.
// - The 512 byte window starts at FFD10 in mode 1 and at FD10 in modes 2 and 3, same top.
// - Bit 0 of the system control register enables the RAM when 1 and disables it when 0.
// - A rising edge of the external reset pin sets the enable bit; software standby leaves it alone.
// - The system control register reads and writes at lower address FFF2 and resets to 0B.
// - With the enable bit set, an access inside the window of the current mode is served by the RAM.
// - In mode 1 with the enable bit clear, window accesses go to the external address space.
// - In modes 2 and 3 with the enable bit clear, window reads return FFFF and writes do nothing.
// - In modes 2 and 3 only the lower 16 address bits are compared with the window limits.
`timescale 1ns/1ps
module onchip_ram_decode_enable #(
  parameter ram_decode_pkg::size_t SIZE_SEL = ram_decode_pkg::SIZE_2K
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [19:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_byte,
  input wire logic [15:0] cpu_wdata,
  output logic cpu_ack,
  output logic [15:0] cpu_rdata,
  output logic ext_req,
  output logic ext_wr,
  output logic ext_byte,
  output logic [19:0] ext_addr,
  output logic [15:0] ext_wdata,
  input wire logic [15:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  input wire logic [1:0] op_mode_pin,
  input wire logic standby_pin,
  input wire logic external_reset_pin,
  output logic onchip_memory_enable
);
  import ram_decode_pkg::*;
  `include "ram_decode_defines.svh"

  // Lowest lower-16-bit address of the window for a given size.
  function automatic logic [15:0] win_base(input size_t sz);
    case (sz)
      SIZE_2K: win_base = `WIN_BASE_2K;
      SIZE_1K: win_base = `WIN_BASE_1K;
      SIZE_512: win_base = `WIN_BASE_512;
      default: win_base = `WIN_BASE_2K;
    endcase
  endfunction

  // True when an address falls in the window of the given mode; mode 0 has no window.
  function automatic logic in_window(input logic [19:0] a, input logic [1:0] md, input size_t sz);
    logic lo_ok;
    lo_ok = (a[15:0] >= win_base(sz)) && (a[15:0] <= `WIN_TOP);
    case (md)
      `MODE_ONE: in_window = lo_ok && (a[19:16] == `WIN_UPPER);
      `MODE_TWO: in_window = lo_ok;
      `MODE_THREE: in_window = lo_ok;
      default: in_window = 1'b0;
    endcase
  endfunction

  logic [1:0] mode_q;
  logic standby_q;
  logic pin_q;
  logic pin_prev_r;
  logic pin_rise;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] sw_rdata_r;
  logic cpu_req;
  logic hit;
  logic mem_en;
  logic serve;
  logic forward;
  logic blocked;
  logic [15:0] offset;
  logic [1:0] mem_we;
  logic [15:0] mem_wdata;
  rd_src_t rd_src;
  logic ack_r;
  logic ext_req_r;
  logic ext_wr_r;
  logic ext_byte_r;
  logic [19:0] ext_addr_r;
  logic [15:0] ext_wdata_r;

  // Mode straps, standby and the reset pin are asynchronous, so each crosses two flip-flops.
  pin_sync #(.W(2), .INIT(2'h0)) u_mode_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(op_mode_pin),
    .q(mode_q)
  );

  pin_sync #(.W(2), .INIT(2'h0)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({standby_pin, external_reset_pin}),
    .q({standby_q, pin_q})
  );

  // Edge detector on the synchronised reset pin.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_q;
    end
  end

  assign pin_rise = pin_q && !pin_prev_r;

  // A software write to the register, then the pin edge on top so that the set wins.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (sw_wr && sw_addr == `SYSTEM_CONTROL_OFS) begin
      ctrl_nxt = sw_wdata;
    end
    if (pin_rise) begin
      ctrl_nxt[`MEM_EN_BIT] = 1'b1;
    end
  end

  // Standby is deliberately not an input here: entering or leaving it cannot touch the enable.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `SYSTEM_CONTROL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Register read port; unmapped addresses read as zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_rdata_r <= 8'h00;
    end else if (sw_rd) begin
      sw_rdata_r <= (sw_addr == `SYSTEM_CONTROL_OFS) ? ctrl_r : 8'h00;
    end
  end

  // Decode of the CPU request against the window of the current mode.
  assign cpu_req = cpu_rd || cpu_wr;
  assign hit = cpu_req && in_window(cpu_addr, mode_q, SIZE_SEL);
  assign mem_en = ctrl_r[`MEM_EN_BIT];
  assign serve = hit && mem_en;
  assign forward = hit && !mem_en && (mode_q == `MODE_ONE);
  assign blocked = hit && !mem_en && (mode_q != `MODE_ONE);

  // Word index within the window; bit 0 of the address picks the byte lane, even is the high lane.
  assign offset = cpu_addr[15:0] - win_base(SIZE_SEL);

  always_comb begin
    mem_we = 2'b00;
    mem_wdata = cpu_wdata;
    if (cpu_byte) begin
      mem_wdata = {cpu_wdata[7:0], cpu_wdata[7:0]};
    end
    if (serve && cpu_wr) begin
      if (!cpu_byte) begin
        mem_we = 2'b11;
      end else if (cpu_addr[0]) begin
        mem_we = 2'b01;
      end else begin
        mem_we = 2'b10;
      end
    end
  end

  // A disabled window in modes 2 and 3 answers all ones and never writes the array.
  always_comb begin
    if (blocked) begin
      rd_src = SRC_ONES;
    end else if (!cpu_byte) begin
      rd_src = SRC_WORD;
    end else if (cpu_addr[0]) begin
      rd_src = SRC_BYTE_LO;
    end else begin
      rd_src = SRC_BYTE_HI;
    end
  end

  ram_store u_ram (
    .clk(clk),
    .addr(offset[10:1]),
    .we(mem_we),
    .wdata(mem_wdata),
    .rd_en(cpu_rd && (serve || blocked)),
    .rd_src(rd_src),
    .rdata(cpu_rdata)
  );

  // Answer in the second state: request in one cycle, acknowledge with data in the next.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= serve || blocked;
    end
  end

  // Forwarded accesses are handed to the external bus logic as a one-cycle request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_req_r <= 1'b0;
      ext_wr_r <= 1'b0;
      ext_byte_r <= 1'b0;
      ext_addr_r <= 20'h00000;
      ext_wdata_r <= 16'h0000;
    end else begin
      ext_req_r <= forward;
      if (forward) begin
        ext_wr_r <= cpu_wr;
        ext_byte_r <= cpu_byte;
        ext_addr_r <= cpu_addr;
        ext_wdata_r <= cpu_wdata;
      end
    end
  end

  assign cpu_ack = ack_r;
  assign ext_req = ext_req_r;
  assign ext_wr = ext_wr_r;
  assign ext_byte = ext_byte_r;
  assign ext_addr = ext_addr_r;
  assign ext_wdata = ext_wdata_r;
  assign sw_rdata = sw_rdata_r;
  assign onchip_memory_enable = ctrl_r[`MEM_EN_BIT];

  // Assertions next to the logic they guard.
  sequence seq_window_req;
    cpu_req && in_window(cpu_addr, mode_q, SIZE_SEL);
  endsequence

  sequence seq_served_req;
    seq_window_req ##0 ctrl_r[`MEM_EN_BIT];
  endsequence

  property p_served_two_states;
    @(posedge clk) disable iff (!rst_n)
      seq_served_req |=> cpu_ack && !ext_req ##1 !cpu_ack || $past(cpu_req);
  endproperty

  chk_served_two_states: assert property (p_served_two_states) else $error("RAM access not acknowledged in state two");

  chk_enable_serves: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_req && ctrl_r[0] && mode_q != 2'h0 && cpu_addr[15:0] == win_base(SIZE_SEL)
      && (mode_q != `MODE_ONE || cpu_addr[19:16] == `WIN_UPPER)) |=> cpu_ack)
    else $error("Enabled window base access was not served");

  chk_window_top_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_req && cpu_addr[15:0] == 16'hFF10) |=> !cpu_ack && !ext_req)
    else $error("Access above window top was claimed");

  chk_window_low_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_req && cpu_addr[15:0] == win_base(SIZE_SEL) - 16'h0001) |=> !cpu_ack && !ext_req)
    else $error("Access below window base was claimed");

  chk_lower_compare: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_req && mode_q == `MODE_THREE && cpu_addr[19:16] == 4'h0 && cpu_addr[15:0] == `WIN_TOP) |=> cpu_ack)
    else $error("Mode 3 compare used more than 16 address bits");

  chk_mode1_forward: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_window_req ##0 (mode_q == `MODE_ONE && !ctrl_r[0])) |=> ext_req && !cpu_ack
      && ext_addr == $past(cpu_addr))
    else $error("Disabled mode 1 access was not forwarded");

  chk_disabled_ones: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_window_req ##0 (cpu_rd && mode_q != `MODE_ONE && !ctrl_r[0])) |=> cpu_ack && cpu_rdata == `ALL_ONES)
    else $error("Disabled window read did not return all ones");

  chk_pin_sets_enable: assert property (@(posedge clk) disable iff (!rst_n)
    pin_rise |=> onchip_memory_enable)
    else $error("Reset pin edge did not set the RAM enable");

  chk_standby_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(standby_q) && !pin_rise && !sw_wr) |=> $stable(onchip_memory_enable))
    else $error("Standby changed the RAM enable");

  chk_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (sw_wr && sw_addr == `SYSTEM_CONTROL_OFS && !pin_rise ##1 sw_rd && sw_addr == `SYSTEM_CONTROL_OFS)
      |=> sw_rdata == $past(sw_wdata, 2))
    else $error("System control register did not read back its write");

  chk_enable_gates: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_wr && !ctrl_r[0]) |-> mem_we == 2'b00)
    else $error("RAM written while disabled");

  // Outside the window, and in mode 0 where there is none, nothing answers and nothing is forwarded.
  chk_outside_unclaimed: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_req && !in_window(cpu_addr, mode_q, SIZE_SEL)) |=> !cpu_ack && !ext_req)
    else $error("Access outside the window was claimed");

  chk_mode0_silent: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_req && mode_q == 2'h0) |=> !cpu_ack && !ext_req)
    else $error("Access in mode 0 was claimed");
endmodule

/* test/cpu_model.sv */
// Partner model of the CPU core: one-cycle read or write strobes on the 16-bit bus.
// Assumes the decoder answers in the cycle after the strobe edge, or not at all.
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  output logic [19:0] cpu_addr,
  output logic cpu_rd,
  output logic cpu_wr,
  output logic cpu_byte,
  output logic [15:0] cpu_wdata,
  input wire logic cpu_ack,
  input wire logic [15:0] cpu_rdata,
  input wire logic ext_req
);
  // The bus is idle from time zero.
  initial begin
    cpu_addr = 20'h00000;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_byte = 1'b0;
    cpu_wdata = 16'h0000;
  end

  // One access of two states: strobe for one cycle, answer taken in the next.
  task automatic access(input logic wr, input logic bt, input logic [19:0] a, input logic [15:0] wd,
                        output logic ack, output logic ext, output logic [15:0] rd);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= ~wr;
    cpu_wr <= wr;
    cpu_byte <= bt;
    cpu_wdata <= wd;
    @(posedge clk);
    // Address and data are inverted after the strobe, so late sampling cannot pass unseen.
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~wd;
    #1;
    ack = cpu_ack;
    ext = ext_req;
    rd = cpu_rdata;
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the on-chip RAM decoder, built for all three memory sizes.
// Assumes one 250 MHz clock; the 1k and 512 byte copies share the CPU inputs and report acks only.
`timescale 1ns/1ps
`include "ram_decode_defines.svh"
module tb_top;
  import ram_decode_pkg::*;
  logic clk, rst_n, cpu_rd, cpu_wr, cpu_byte, cpu_ack, ext_req, ext_wr, ext_byte, ack_1k, ack_512;
  logic [19:0] cpu_addr, ext_addr;
  logic [15:0] cpu_wdata, cpu_rdata, ext_wdata, sw_addr, rd_s;
  logic [7:0] sw_wdata, sw_rdata;
  logic sw_wr, sw_rd, standby_pin, external_reset_pin, onchip_memory_enable, ack_s, ext_s;
  logic [1:0] op_mode_pin;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  cpu_model i_cpu_model (.clk(clk), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_byte(cpu_byte), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .ext_req(ext_req));
  onchip_ram_decode_enable #(.SIZE_SEL(SIZE_2K)) i_onchip_ram_decode_enable (.clk(clk), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_byte(cpu_byte), .cpu_wdata(cpu_wdata),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .ext_req(ext_req), .ext_wr(ext_wr), .ext_byte(ext_byte),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .op_mode_pin(op_mode_pin), .standby_pin(standby_pin),
    .external_reset_pin(external_reset_pin), .onchip_memory_enable(onchip_memory_enable));
  onchip_ram_decode_enable #(.SIZE_SEL(SIZE_1K)) i_onchip_ram_decode_enable_1k (.clk(clk), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_byte(cpu_byte), .cpu_wdata(cpu_wdata),
    .cpu_ack(ack_1k), .cpu_rdata(), .ext_req(), .ext_wr(), .ext_byte(), .ext_addr(), .ext_wdata(),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(), .op_mode_pin(op_mode_pin),
    .standby_pin(standby_pin), .external_reset_pin(external_reset_pin), .onchip_memory_enable());
  onchip_ram_decode_enable #(.SIZE_SEL(SIZE_512)) i_onchip_ram_decode_enable_512 (.clk(clk), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_byte(cpu_byte), .cpu_wdata(cpu_wdata),
    .cpu_ack(ack_512), .cpu_rdata(), .ext_req(), .ext_wr(), .ext_byte(), .ext_addr(), .ext_wdata(),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(), .op_mode_pin(op_mode_pin),
    .standby_pin(standby_pin), .external_reset_pin(external_reset_pin), .onchip_memory_enable());

  // Free-running clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cpu(input logic wr, input logic bt, input logic [19:0] a, input logic [15:0] wd);
    i_cpu_model.access(wr, bt, a, wd, ack_s, ext_s, rd_s);
  endtask

  task automatic sw_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  // Write, then read in the very next cycle, so the strobes follow with no gap.
  task automatic sw_write_read(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 q = sw_rdata;
  endtask

  task automatic sw_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // The mode pins pass a two-flop synchroniser, so four edges are allowed before use.
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    op_mode_pin <= m;
    repeat (4) @(posedge clk);
  endtask

  // Both edges of every window in every mode; modes 2 and 3 carry a foreign upper nibble.
  task automatic test_window();
    logic [15:0] lo [8];
    logic [3:0] hi;
    lo = '{16'hF70F, 16'hF710, 16'hFB0F, 16'hFB10, 16'hFD0F, 16'hFD10, 16'hFF0F, 16'hFF10};
    for (int m = 1; m <= 3; m++) begin
      set_mode(m[1:0]);
      hi = (m == 1) ? 4'hF : ((m == 3) ? 4'h0 : 4'h3);
      for (int i = 0; i < 8; i++) begin
        cpu(1'b0, 1'b0, {hi, lo[i]}, 16'h0000);
        check("ack 2k", 20'(lo[i] >= `WIN_BASE_2K && lo[i] <= `WIN_TOP), 20'(ack_s));
        check("ack 1k", 20'(lo[i] >= `WIN_BASE_1K && lo[i] <= `WIN_TOP), 20'(ack_1k));
        check("ack 512", 20'(lo[i] >= `WIN_BASE_512 && lo[i] <= `WIN_TOP), 20'(ack_512));
        check("no forward", 20'h0, 20'(ext_s));
      end
    end
    set_mode(2'h0);
    cpu(1'b0, 1'b0, 20'hFFF0F, 16'h0000);
    check("mode 0 silent", 20'h0, 20'({ack_s, ext_s}));
    set_mode(2'h1);
    cpu(1'b0, 1'b0, 20'hEF710, 16'h0000);
    check("mode 1 upper nibble", 20'h0, 20'(ack_s));
  endtask

  // Word and byte lanes, including the top word of the window.
  task automatic test_data();
    set_mode(2'h2);
    cpu(1'b1, 1'b0, 20'h0F710, 16'h1234);
    check("word write ack", 20'h1, 20'(ack_s));
    cpu(1'b1, 1'b0, 20'h0F712, 16'h5678);
    cpu(1'b1, 1'b1, 20'h0F713, 16'h00CD);
    cpu(1'b1, 1'b0, 20'h0FF0E, 16'hBEEF);
    cpu(1'b0, 1'b1, 20'h0F710, 16'h0000);
    check("byte even", 20'h0012, 20'(rd_s));
    cpu(1'b0, 1'b1, 20'h0F711, 16'h0000);
    check("byte odd", 20'h0034, 20'(rd_s));
    cpu(1'b0, 1'b0, 20'h0F712, 16'h0000);
    check("word merge", 20'h56CD, 20'(rd_s));
    cpu(1'b0, 1'b0, 20'h0FF0E, 16'h0000);
    check("top word", 20'hBEEF, 20'(rd_s));
  endtask

  // Register access, then the disabled behaviour of modes 2 and 1.
  task automatic test_disable();
    logic [7:0] v;
    sw_write(16'hFFF3, 8'h00);
    sw_read(16'hFFF2, v);
    check("reset value", 20'(`SYSTEM_CONTROL_RESET), 20'(v));
    sw_read(16'hFFF3, v);
    check("unmapped read", 20'h0, 20'(v));
    sw_write_read(16'hFFF2, 8'hF4, v);
    check("other bits kept", 20'hF4, 20'(v));
    check("enable cleared", 20'h0, 20'(onchip_memory_enable));
    cpu(1'b0, 1'b0, 20'h3F710, 16'h0000);
    check("disabled word", 20'(`ALL_ONES), 20'(rd_s));
    cpu(1'b0, 1'b1, 20'h3F711, 16'h0000);
    check("disabled byte", 20'(`ALL_ONES), 20'(rd_s));
    cpu(1'b1, 1'b0, 20'h3F710, 16'h0000);
    check("disabled write ack", 20'h1, 20'(ack_s));
    set_mode(2'h1);
    cpu(1'b0, 1'b0, 20'hFF710, 16'h0000);
    check("forward read", 20'h1, 20'(ext_s));
    check("forward no ack", 20'h0, 20'(ack_s));
    check("forward addr", 20'hFF710, ext_addr);
    cpu(1'b1, 1'b1, 20'hFFF0F, 16'h0077);
    check("forward write", 20'h1, 20'({ext_s, ext_wr, ext_byte} == 3'b111));
    check("forward data", 20'h0077, 20'(ext_wdata));
    sw_write(16'hFFF2, 8'h0B);
    set_mode(2'h3);
    cpu(1'b0, 1'b0, 20'h0F710, 16'h0000);
    check("write ignored", 20'h1234, 20'(rd_s));
  endtask

  // Standby leaves the enable alone; a rising reset pin sets it again.
  task automatic test_pins();
    logic [7:0] v;
    sw_write(16'hFFF2, 8'h0A);
    @(posedge clk);
    standby_pin <= 1'b1;
    repeat (6) @(posedge clk);
    standby_pin <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check("standby keeps enable", 20'h0, 20'(onchip_memory_enable));
    @(posedge clk);
    external_reset_pin <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check("pin rise sets enable", 20'h1, 20'(onchip_memory_enable));
    sw_read(16'hFFF2, v);
    check("register after pin", 20'h0B, 20'(v));
    @(posedge clk);
    external_reset_pin <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Main sequence: two cycles of reset, then the scenarios in order.
  initial begin
    rst_n = 1'b0;
    sw_addr = 16'h0000;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    op_mode_pin = 2'h2;
    standby_pin = 1'b0;
    external_reset_pin = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_window();
    test_data();
    test_disable();
    test_pins();
    give_verdict();
  end
endmodule
